// ==== logic/pirq_bank.sv ====
// peripheral interrupt flag, enable and priority bank with a classic wishbone slave
// assumes event inputs are one-cycle pulses synchronous to clk_sys_i; rx/tx levels come
// from the serial unit, which sees rx_buffer reads and tx_buffer writes itself
`timescale 1ns/100ps
module pirq_bank #(
  parameter int unsigned ADDR_W = 5
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic parport_access_i,
  input wire logic conv_done_i,
  input wire logic rx_buffer_full_i,
  input wire logic tx_buffer_empty_i,
  input wire logic sync_serial_done_i,
  input wire logic capcmp_one_event_i,
  input wire logic timer_two_match_i,
  input wire logic timer_one_ovf_i,
  input wire logic mem_write_done_i,
  input wire logic bus_collision_i,
  input wire logic low_voltage_i,
  input wire logic timer_three_ovf_i,
  input wire logic capcmp_two_event_i,
  output logic irq_high_o,
  output logic irq_low_o,
  output logic [7:0] req_1_o,
  output logic [4:0] req_2_o
);
  import pirq_pkg::*;

  // bank select is the bit just above the offset; other widths have no decode
  if (ADDR_W != PIRQ_AW + 1) begin : g_bad_addr_w
    $error("pirq_bank: ADDR_W must be PIRQ_AW + 1");
  end

  logic [7:0] flags_1_q;
  logic [4:0] flags_2_q;
  logic [7:0] en_1_q;
  logic [4:0] en_2_q;
  logic [7:0] prio_1_q;
  logic global_en_q;
  logic group_en_q;
  logic prio_mode_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic req_hi_q;
  logic req_lo_q;
  logic [7:0] req_1_q;
  logic [4:0] req_2_q;

  logic access;
  logic wr;
  logic bank;
  logic [PIRQ_AW-1:0] ofs;
  logic [7:0] wbyte;
  logic [7:0] ev_1;
  logic [4:0] ev_2;
  logic [7:0] live_1;
  logic [7:0] flags_1_rd;
  logic [12:0] pend;
  logic [12:0] prio_all;
  logic any_hi;
  logic any_lo;

  // a new access starts only when ack is low; gives one wait state and a gap between
  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = access && wb_we_i && wb_sel_i[0];
  assign bank = wb_adr_i[ADDR_W-1];
  assign ofs = wb_adr_i[PIRQ_AW-1:0];
  assign wbyte = wb_dat_i[7:0];

  function automatic logic hit(input logic b, input logic [PIRQ_AW-1:0] o,
                               input logic want_b, input logic [PIRQ_AW-1:0] want_o);
    hit = (b == want_b) && (o == want_o);
  endfunction

  // event vectors in register bit order
  always_comb begin
    ev_1 = 8'h00;
    ev_1[PIRQ_B_PARPORT] = parport_access_i;
    ev_1[PIRQ_B_CONV] = conv_done_i;
    ev_1[PIRQ_B_SSP] = sync_serial_done_i;
    ev_1[PIRQ_B_CC1] = capcmp_one_event_i;
    ev_1[PIRQ_B_T2] = timer_two_match_i;
    ev_1[PIRQ_B_T1] = timer_one_ovf_i;
    ev_2 = 5'h00;
    ev_2[PIRQ_B_MEMWR] = mem_write_done_i;
    ev_2[PIRQ_B_BCOL] = bus_collision_i;
    ev_2[PIRQ_B_LVD] = low_voltage_i;
    ev_2[PIRQ_B_T3] = timer_three_ovf_i;
    ev_2[PIRQ_B_CC2] = capcmp_two_event_i;
  end

  // rx/tx bits are live status, not stored
  always_comb begin
    live_1 = flags_1_q;
    live_1[PIRQ_B_RX] = rx_buffer_full_i;
    live_1[PIRQ_B_TX] = tx_buffer_empty_i;
    flags_1_rd = live_1;
  end

  // sticky flags; an event in the clearing cycle wins over the write
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      flags_1_q <= PIRQ_RST_FLAGS;
    end else if (wr && hit(bank, ofs, 1'b0, PIRQ_OFS_FLAGS_1)) begin
      flags_1_q <= (wbyte & ~8'h30) | ev_1;
    end else begin
      flags_1_q <= flags_1_q | ev_1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      flags_2_q <= PIRQ_RST_FLAGS[4:0];
    end else if (wr && hit(bank, ofs, 1'b0, PIRQ_OFS_FLAGS_2)) begin
      flags_2_q <= wbyte[4:0] | ev_2;
    end else begin
      flags_2_q <= flags_2_q | ev_2;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      en_1_q <= PIRQ_RST_ENABLES;
      en_2_q <= PIRQ_RST_ENABLES[4:0];
      prio_1_q <= PIRQ_RST_PRIO;
    end else begin
      if (wr && hit(bank, ofs, 1'b0, PIRQ_OFS_ENABLES_1)) begin
        en_1_q <= wbyte;
      end
      if (wr && hit(bank, ofs, 1'b0, PIRQ_OFS_ENABLES_2)) begin
        en_2_q <= wbyte[4:0];
      end
      if (wr && hit(bank, ofs, 1'b1, PIRQ_OFS_PRIORITY_1)) begin
        prio_1_q <= wbyte;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      global_en_q <= 1'b0;
      group_en_q <= 1'b0;
      prio_mode_q <= 1'b0;
    end else begin
      if (wr && hit(bank, ofs, 1'b1, PIRQ_OFS_CORE_CTRL)) begin
        global_en_q <= wbyte[PIRQ_B_GLOBAL_EN];
        group_en_q <= wbyte[PIRQ_B_GROUP_EN];
      end
      if (wr && hit(bank, ofs, 1'b1, PIRQ_OFS_RESET_CTRL)) begin
        prio_mode_q <= wbyte[PIRQ_B_PRIO_MODE];
      end
    end
  end

  // pending = flag and enable; second bank has no priority register here, fixed high
  assign pend = {live_1 & en_1_q, flags_2_q & en_2_q};
  assign prio_all = {prio_1_q, PIRQ_PRIO_2_FIXED[4:0]};
  assign any_hi = |(pend & prio_all);
  assign any_lo = |(pend & ~prio_all);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      req_hi_q <= 1'b0;
      req_lo_q <= 1'b0;
      req_1_q <= 8'h00;
      req_2_q <= 5'h00;
    end else begin
      req_1_q <= pend[12:5];
      req_2_q <= pend[4:0];
      if (prio_mode_q) begin
        // high requests need the global bit, low ones the group bit
        req_hi_q <= any_hi && global_en_q;
        req_lo_q <= any_lo && group_en_q;
      end else begin
        // priority bits ignored, all on high output
        req_hi_q <= (|pend) && group_en_q && global_en_q;
        req_lo_q <= 1'b0;
      end
    end
  end

  assign irq_high_o = req_hi_q;
  assign irq_low_o = req_lo_q;
  assign req_1_o = req_1_q;
  assign req_2_o = req_2_q;

  // read mux, registered with the ack
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
      rdata_q <= PIRQ_RD_DEFAULT;
    end else begin
      ack_q <= access;
      rdata_q <= PIRQ_RD_DEFAULT;
      if (access && !wb_we_i) begin
        case ({bank, ofs})
          {1'b0, PIRQ_OFS_FLAGS_1}: rdata_q[7:0] <= flags_1_rd;
          {1'b0, PIRQ_OFS_FLAGS_2}: rdata_q[4:0] <= flags_2_q;
          {1'b0, PIRQ_OFS_ENABLES_1}: rdata_q[7:0] <= en_1_q;
          {1'b0, PIRQ_OFS_ENABLES_2}: rdata_q[4:0] <= en_2_q;
          {1'b1, PIRQ_OFS_PRIORITY_1}: rdata_q[7:0] <= prio_1_q;
          {1'b1, PIRQ_OFS_CORE_CTRL}: begin
            rdata_q[PIRQ_B_GLOBAL_EN] <= global_en_q;
            rdata_q[PIRQ_B_GROUP_EN] <= group_en_q;
          end
          {1'b1, PIRQ_OFS_RESET_CTRL}: rdata_q[PIRQ_B_PRIO_MODE] <= prio_mode_q;
          {1'b1, PIRQ_OFS_REQ_STATUS}: rdata_q[1:0] <= {req_hi_q, req_lo_q};
          default: rdata_q <= PIRQ_RD_DEFAULT;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
endmodule

// ==== logic/pirq_pkg.sv ====
// package for the peripheral interrupt request bank: offsets, field positions, resets
// assumes an 8-bit register view placed in the low bits of a 32-bit wishbone word
package pirq_pkg;
  localparam int unsigned PIRQ_AW = 4;
  // word offsets as byte addresses
  localparam logic [PIRQ_AW-1:0] PIRQ_OFS_FLAGS_1 = 4'h0;
  localparam logic [PIRQ_AW-1:0] PIRQ_OFS_FLAGS_2 = 4'h4;
  localparam logic [PIRQ_AW-1:0] PIRQ_OFS_ENABLES_1 = 4'h8;
  localparam logic [PIRQ_AW-1:0] PIRQ_OFS_ENABLES_2 = 4'hc;
  localparam logic [PIRQ_AW-3:0] PIRQ_IDX_PRIORITY_1 = 2'h0;
  // second bank: priority 1, core control, reset control and request status words
  localparam logic [PIRQ_AW-1:0] PIRQ_OFS_PRIORITY_1 = 4'h0;
  localparam logic [PIRQ_AW-1:0] PIRQ_OFS_CORE_CTRL = 4'h4;
  localparam logic [PIRQ_AW-1:0] PIRQ_OFS_RESET_CTRL = 4'h8;
  localparam logic [PIRQ_AW-1:0] PIRQ_OFS_REQ_STATUS = 4'hc;
  // flag register 1 bit positions
  localparam int unsigned PIRQ_B_PARPORT = 7;
  localparam int unsigned PIRQ_B_CONV = 6;
  localparam int unsigned PIRQ_B_RX = 5;
  localparam int unsigned PIRQ_B_TX = 4;
  localparam int unsigned PIRQ_B_SSP = 3;
  localparam int unsigned PIRQ_B_CC1 = 2;
  localparam int unsigned PIRQ_B_T2 = 1;
  localparam int unsigned PIRQ_B_T1 = 0;
  // flag register 2 bit positions
  localparam int unsigned PIRQ_B_MEMWR = 4;
  localparam int unsigned PIRQ_B_BCOL = 3;
  localparam int unsigned PIRQ_B_LVD = 2;
  localparam int unsigned PIRQ_B_T3 = 1;
  localparam int unsigned PIRQ_B_CC2 = 0;
  localparam int unsigned PIRQ_W2 = 5;
  // core control / reset control bit positions
  localparam int unsigned PIRQ_B_GLOBAL_EN = 7;
  localparam int unsigned PIRQ_B_GROUP_EN = 6;
  localparam int unsigned PIRQ_B_PRIO_MODE = 7;
  // reset values, fixed second-bank priority and second-bank mask
  localparam logic [7:0] PIRQ_RST_FLAGS = 8'h00;
  localparam logic [7:0] PIRQ_RST_ENABLES = 8'h00;
  localparam logic [7:0] PIRQ_RST_PRIO = 8'hff;
  localparam logic [7:0] PIRQ_PRIO_2_FIXED = 8'h1f;
  localparam logic [7:0] PIRQ_MASK_2 = 8'h1f;
  localparam logic [31:0] PIRQ_RD_DEFAULT = 32'h0000_0000;
endpackage

// ==== testbench/pirq_bank_asserts.sv ====
// checker for the request bank: bus answer timing, read data, request holding
// assumes it is bound to pirq_bank and sees only that module's ports
`timescale 1ns/100ps
module pirq_bank_asserts (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_high_o,
  input wire logic irq_low_o,
  input wire logic [7:0] req_1_o,
  input wire logic [4:0] req_2_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  logic wr;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i;
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o)
    |=> wb_ack_o) else $error("ack not one cycle after request");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_wr_dat_zero: assert property (wb_ack_o && $past(wr) |-> wb_dat_o == 32'h0)
    else $error("read data on write ack");
  // a request bit only drops after a write; rx/tx level bits excepted
  a_req1_hold: assert property (|($past(req_1_o) & ~req_1_o & 8'hcf)
    |-> $past(wr) || $past(wr, 2)) else $error("request one dropped without write");
  a_req2_hold: assert property (|($past(req_2_o) & ~req_2_o)
    |-> $past(wr) || $past(wr, 2)) else $error("request two dropped without write");
  a_irq_cause: assert property ((irq_high_o || irq_low_o)
    |-> |{req_1_o, req_2_o, $past(req_1_o), $past(req_2_o)}) else $error("irq without request");
endmodule

// ==== testbench/pirq_src_model.sv ====
// peripheral event source model: registers fire requests onto the event lines one clock later
// assumes fire_i changes just after a rising edge of clk_sys_i
`timescale 1ns/100ps
module pirq_src_model (
  input wire logic clk_sys_i,
  input wire logic [12:0] fire_i,
  output logic [12:0] ev_o
);
  // sources pulse, never hold: a held line would hide the software clear
  always_ff @(posedge clk_sys_i) begin
    ev_o <= fire_i;
  end
endmodule

// ==== testbench/pirq_bank_tb.sv ====
// testbench for the request bank: wishbone master, event pulses, irq routing
// assumes the checker and source model are compiled before this file
`timescale 1ns/100ps
module pirq_bank_tb;
  import pirq_pkg::*;
  logic clk_sys_i = 0, rstn_i = 0, cyc = 0, we = 0, rx = 0, tx = 1, ack, irq_h, irq_l;
  logic [3:0] sel = 4'h1;
  logic [4:0] adr = '0, req2;
  logic [7:0] req1, f1, e1;
  logic [12:0] fire = '0, ev;
  logic [31:0] dat = '0, rd, dat_o;
  int failures = 0, compares = 0, seed = 38, i;
  pirq_src_model pirq_src_model_inst (.clk_sys_i, .fire_i(fire), .ev_o(ev));
  pirq_bank pirq_bank_inst (.clk_sys_i, .rstn_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .parport_access_i(ev[7]), .conv_done_i(ev[6]), .rx_buffer_full_i(rx),
    .tx_buffer_empty_i(tx), .sync_serial_done_i(ev[3]), .capcmp_one_event_i(ev[2]),
    .timer_two_match_i(ev[1]), .timer_one_ovf_i(ev[0]), .mem_write_done_i(ev[12]),
    .bus_collision_i(ev[11]), .low_voltage_i(ev[10]), .timer_three_ovf_i(ev[9]),
    .capcmp_two_event_i(ev[8]), .irq_high_o(irq_h), .irq_low_o(irq_l), .req_1_o(req1),
    .req_2_o(req2));
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  function automatic logic [4:0] fa(int k);
    return (k < 8) ? 5'h00 : 5'h04;
  endfunction
  function automatic logic [7:0] fb(int k);
    return 8'h01 << (k % 8);
  endfunction
  function automatic logic [7:0] ereq(logic [7:0] f, logic [7:0] e);
    return ((f & 8'hcf) | {2'b0, rx, tx, 4'h0}) & e;
  endfunction
  task automatic results;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk_sys_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    wb(0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task automatic pulse(int k);
    @(posedge clk_sys_i);
    fire[k] <= 1;
    @(posedge clk_sys_i);
    fire[k] <= 0;
  endtask
  // ctrl, mode, priority written, then irq pair checked once settled
  task automatic rt(input logic [7:0] c, m, p, input logic [1:0] e);
    wb(1, 5'h14, c);
    wb(1, 5'h18, m);
    wb(1, 5'h10, p);
    repeat (3) @(posedge clk_sys_i);
    chk({30'h0, irq_h, irq_l}, {30'h0, e});
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1;
    chk(32'({irq_h, irq_l, req1, req2}), 32'h0);
    rc(5'h00, 8'h10);
    rc(5'h04, 8'h00);
    rc(5'h08, 8'h00);
    rc(5'h0c, 8'h00);
    rc(5'h10, 8'hff);
    rc(5'h18, 8'h00);
    tx <= 0;
    for (i = 0; i < 13; i++) if (i != 4 && i != 5) begin
      pulse(i);
      rc(fa(i), fb(i));
      rc(fa(i), fb(i));
      wb(1, fa(i), 8'h00);
      rc(fa(i), 8'h00);
    end
    rx <= 1;
    wb(1, 5'h00, 8'h30);
    rc(5'h00, 8'h20);
    rx <= 0;
    tx <= 1;
    wb(1, 5'h03, 8'hff);
    rc(5'h03, 8'h00);
    sel <= 4'h0;
    wb(1, 5'h08, 8'hff);
    sel <= 4'h1;
    rc(5'h08, 8'h00);
    for (i = 0; i < 6; i++) begin
      f1 = 8'($random(seed));
      e1 = 8'($random(seed));
      wb(1, 5'h00, f1);
      wb(1, 5'h04, f1);
      wb(1, 5'h08, e1);
      wb(1, 5'h0c, e1);
      rc(5'h0c, e1 & PIRQ_MASK_2);
      chk(32'(req1), 32'(ereq(f1, e1)));
      chk(32'(req2), 32'(f1 & e1 & 8'h1f));
    end
    wb(1, 5'h04, 8'h00);
    wb(1, 5'h0c, 8'h00);
    wb(1, 5'h00, 8'h01);
    wb(1, 5'h08, 8'h01);
    rt(8'hc0, 8'h00, 8'hff, 2'b10);
    rt(8'h80, 8'h00, 8'hff, 2'b00);
    rt(8'hc0, 8'h80, 8'h80, 2'b01);
    rt(8'h40, 8'h80, 8'h80, 2'b01);
    rt(8'h40, 8'h80, 8'hff, 2'b00);
    rt(8'hc0, 8'h00, 8'h80, 2'b10);
    rc(5'h14, 8'hc0);
    rc(5'h1c, 8'h02);
    rstn_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    chk({30'h0, irq_h, irq_l}, 32'h0);
    rstn_i <= 1;
    rc(5'h08, 8'h00);
    rc(5'h10, 8'hff);
    rc(5'h14, 8'h00);
    results;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    results;
  end
endmodule
bind pirq_bank pirq_bank_asserts pirq_bank_asserts_inst (.*);
